// >>> axis_origin_pkg.sv
/*
  Shared constants and types for the per-axis origin search block.
  Assumes a 32-bit classic Wishbone bus with byte addresses and one servo clock.
*/
`default_nettype none
package axis_origin_pkg;
  localparam int NAXES = 4;
  localparam int AXW   = 2;
  localparam int POSW  = 32;
  localparam int SPDW  = 16;
  localparam int NIN   = 8;
  localparam int INSW  = 3;
  localparam int STW   = 16;
  localparam int ADR_W = 8;
  localparam int DW    = 32;
  localparam int SELW  = 4;
  // Status word bit positions
  localparam int ST_FE_WARN  = 1;
  localparam int ST_COMM_ERR = 2;
  localparam int ST_DRV_ERR  = 3;
  localparam int ST_FOLLOWING_ERROR_LIMIT = 8;
  localparam int ST_CANCEL   = 11;
  // Address regions (adr[7:5]) and words within the general region (adr[4:2])
  localparam logic [2:0] RGN_GEN   = 3'h0;
  localparam logic [2:0] RGN_STAT  = 3'h1;
  localparam logic [2:0] RGN_DEM   = 3'h2;
  localparam logic [2:0] RGN_MEAS  = 3'h3;
  localparam logic [2:0] RGN_CREEP = 3'h4;
  localparam logic [2:0] RGN_SPEED = 3'h5;
  localparam logic [2:0] RGN_OSEL  = 3'h6;
  localparam logic [2:0] GEN_CMD   = 3'h0;
  localparam logic [2:0] GEN_BASE  = 3'h1;
  localparam logic [2:0] GEN_IRQ_ST  = 3'h2;
  localparam logic [2:0] GEN_IRQ_MSK = 3'h3;
  localparam logic [2:0] GEN_PINS  = 3'h4;
  localparam int BUSY_BIT  = 31;
  localparam int STATE_LSB = 16;
  // Search sequences
  localparam logic [2:0] SEQ_ALIGN   = 3'h0;
  localparam logic [2:0] SEQ_Z_FWD   = 3'h1;
  localparam logic [2:0] SEQ_Z_REV   = 3'h2;
  localparam logic [2:0] SEQ_SW_FWD  = 3'h3;
  localparam logic [2:0] SEQ_SW_REV  = 3'h4;
  localparam logic [2:0] SEQ_SWZ_FWD = 3'h5;
  localparam logic [2:0] SEQ_SWZ_REV = 3'h6;
  localparam logic [2:0] SEQ_MAX     = 3'h6;
  // Interrupt status bits
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_ALIGN = 1;
  localparam int IRQ_REJ   = 2;
  localparam int NIRQ      = 3;
  // Reset values
  localparam logic [SPDW-1:0] RST_CREEP = 16'h0010;
  localparam logic [SPDW-1:0] RST_SPEED = 16'h0100;
  localparam logic [INSW-1:0] RST_OSEL  = 3'h0;

  typedef struct packed {
    logic [AXW-1:0] axis;
    logic           temp;
    logic [2:0]     seq;
  } cmd_t;
  localparam int CMD_W = $bits(cmd_t);

  typedef struct packed {
    logic cancel;
    logic following_error_limit;
    logic drv_err;
    logic comm_err;
    logic fe_warn;
  } err_t;

  typedef struct packed {
    logic rev_lim;
    logic fwd_lim;
    logic fwd_jog;
    logic rev_jog;
    logic hold;
  } ctl_pins_t;
  localparam int NCP = $bits(ctl_pins_t);
endpackage : axis_origin_pkg
`default_nettype wire

// >>> axis_origin_search.sv
/*
  Origin search and error clear for a group of servo axes, with a Wishbone
  register slave and one level interrupt.
  Assumes encoder positions and error causes come from logic on clk_i, and
  that switch, index and control pins are asynchronous.
*/
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Six searches home axis, clear status
// - Creep speed register gives slow speed
// - Speed register gives fast speed
// - Sequences 3-6 use selected origin input
// - Base axis unless temporary axis given
// - Origin switch asserted when input low
// - Hold, jog, limit pins active low
// - Sequence 0 loads measured into demand
// - Sequence 0 clears error bits, all axes
// - Status bits 1,2,3,8,11 defined
// - Persisting cause keeps its bit set
// - Sequences 1,2 creep to index marker
// - Sequences 3,4 fast to switch, creep off
// - Sequences 5,6 then creep to index
// - Finish zeroes demand, keeps following error
module axis_origin_search (
  // Clock and reset
  input  wire logic                                     clk_i,
  input  wire logic                                     rst_i,
  // Wishbone slave
  input  wire logic                                     wb_cyc_i,
  input  wire logic                                     wb_stb_i,
  input  wire logic                                     wb_we_i,
  input  wire logic [axis_origin_pkg::ADR_W-1:0]        wb_adr_i,
  input  wire logic [axis_origin_pkg::SELW-1:0]         wb_sel_i,
  input  wire logic [axis_origin_pkg::DW-1:0]           wb_dat_i,
  output logic      [axis_origin_pkg::DW-1:0]           wb_dat_o,
  output logic                                          wb_ack_o,
  // Pins
  input  wire logic [axis_origin_pkg::NIN-1:0]          gen_in_i,
  input  wire logic [axis_origin_pkg::NAXES-1:0]        index_i,
  input  wire axis_origin_pkg::ctl_pins_t               ctl_pins_i,
  // Axis feedback and causes
  input  wire logic [axis_origin_pkg::NAXES-1:0][axis_origin_pkg::POSW-1:0] enc_pos_i,
  input  wire axis_origin_pkg::err_t [axis_origin_pkg::NAXES-1:0] err_cond_i,
  // Motion and status
  output axis_origin_pkg::ctl_pins_t                    ctl_active_o,
  output logic [axis_origin_pkg::NAXES-1:0][axis_origin_pkg::POSW-1:0] dem_pos_o,
  output logic signed [axis_origin_pkg::POSW-1:0]       vel_o,
  output logic [axis_origin_pkg::AXW-1:0]               vel_axis_o,
  output logic                                          busy_o,
  output logic                                          irq_o
);
  import axis_origin_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_FAST, S_BACK, S_ZSEEK, S_ZERO} state_t;

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_v,
                                          input logic [DW-1:0] new_v,
                                          input logic [SELW-1:0] sel);
    logic [DW-1:0] r;
    r = old_v;
    for (int i = 0; i < SELW; i++)
      if (sel[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction : merge

  function automatic logic signed [POSW-1:0] ext(input logic [SPDW-1:0] m);
    return signed'({{(POSW-SPDW){1'b0}}, m});
  endfunction : ext

  state_t                 state_q;
  logic [AXW-1:0]         base_q;
  logic [AXW-1:0]         ax_q;
  logic                   fwd_q;
  logic [2:0]             seq_q;
  logic [SPDW-1:0]        creep_q [NAXES];
  logic [SPDW-1:0]        speed_q [NAXES];
  logic [INSW-1:0]        osel_q  [NAXES];
  logic signed [POSW-1:0] dem_q   [NAXES];
  logic signed [POSW-1:0] ofs_q   [NAXES];
  logic signed [POSW-1:0] meas    [NAXES];
  logic [NIRQ-1:0]        irq_st_q;
  logic [NIRQ-1:0]        irq_msk_q;
  logic [NIRQ-1:0]        irq_ev;
  logic                   ack_q;
  logic [DW-1:0]          dat_q;
  logic [DW-1:0]          rd_d;
  logic signed [POSW-1:0] vel_q;
  logic signed [POSW-1:0] vel_d;
  logic [SPDW-1:0]        mag_d;
  ctl_pins_t              ctl_act_q;
  logic [NIN-1:0]         in_s;
  logic [NAXES-1:0]       idx_s;
  logic [NAXES-1:0]       idx_prev_q;
  logic [NCP-1:0]         ctl_s;
  logic [STW-1:0]         stat_w  [NAXES];
  logic [NAXES-1:0]       clr_ax;

  // Pin synchronisers; active-low pins reset to idle high so that neither a
  // switch hit nor a pin assertion shows up for two cycles after reset
  pin_sync #(.W(NIN), .RST_VAL({NIN{1'b1}})) u_in_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (gen_in_i),
    .q_o   (in_s)
  );

  pin_sync #(.W(NAXES), .RST_VAL({NAXES{1'b0}})) u_idx_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (index_i),
    .q_o   (idx_s)
  );

  pin_sync #(.W(NCP), .RST_VAL({NCP{1'b1}})) u_ctl_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (ctl_pins_i),
    .q_o   (ctl_s)
  );

  // Bus decode
  logic       req;
  logic       wr;
  logic [2:0] rgn;
  logic [2:0] idx;
  logic       ax_ok;
  logic [AXW-1:0] idx_ax;
  cmd_t       cmd;
  logic       cmd_go;
  logic       accept;
  logic       reject;
  logic       align;
  logic [AXW-1:0] sel_ax;
  logic       org_act;
  logic       idx_rise;

  assign req    = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr     = req & wb_we_i;
  assign rgn    = wb_adr_i[7:5];
  assign idx    = wb_adr_i[4:2];
  assign idx_ax = idx[AXW-1:0];
  assign ax_ok  = 32'(idx) < NAXES;
  assign cmd    = cmd_t'(wb_dat_i[CMD_W-1:0]);
  assign cmd_go = wr & (rgn == RGN_GEN) & (idx == GEN_CMD) & wb_sel_i[0];
  assign accept = cmd_go & (cmd.seq <= SEQ_MAX) & (state_q == S_IDLE);
  assign reject = cmd_go & ~accept;
  assign sel_ax = cmd.temp ? cmd.axis : base_q;
  assign align  = accept & (cmd.seq == SEQ_ALIGN);

  // Switch reads off when asserted; fail-safe against a broken wire
  assign org_act  = ~in_s[osel_q[ax_q]];
  assign idx_rise = idx_s[ax_q] & ~idx_prev_q[ax_q];

  always_comb
  begin
    for (int a = 0; a < NAXES; a++)
      meas[a] = signed'(enc_pos_i[a]) + ofs_q[a];
  end

  // Speed selection
  always_comb
  begin
    mag_d = '0;
    unique case (state_q)
      S_FAST:          mag_d = speed_q[ax_q];
      S_BACK, S_ZSEEK: mag_d = creep_q[ax_q];
      S_IDLE, S_ZERO:  mag_d = '0;
    endcase
    if (ctl_act_q.hold)
      mag_d = '0;
    vel_d = fwd_q ? ext(mag_d) : -ext(mag_d);
  end

  // Sequence state machine
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= S_IDLE;
      ax_q    <= '0;
      fwd_q   <= 1'b1;
      seq_q   <= SEQ_ALIGN;
    end
    else
    begin
      unique case (state_q)
        S_IDLE:
          if (accept)
          begin
            ax_q  <= sel_ax;
            seq_q <= cmd.seq;
            fwd_q <= (cmd.seq == SEQ_Z_FWD) | (cmd.seq == SEQ_SW_FWD)
                     | (cmd.seq == SEQ_SWZ_FWD);
            if (cmd.seq == SEQ_Z_FWD || cmd.seq == SEQ_Z_REV)
              state_q <= S_ZSEEK;
            else if (cmd.seq != SEQ_ALIGN)
              state_q <= S_FAST;
          end
        S_FAST:
          if (org_act)
          begin
            fwd_q   <= ~fwd_q;
            state_q <= S_BACK;
          end
        S_BACK:
          if (!org_act)
            state_q <= (seq_q == SEQ_SWZ_FWD || seq_q == SEQ_SWZ_REV)
                       ? S_ZSEEK : S_ZERO;
        S_ZSEEK:
          if (idx_rise)
            state_q <= S_ZERO;
        S_ZERO:
          state_q <= S_IDLE;
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  // Demand position and measured offset per axis
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int a = 0; a < NAXES; a++)
      begin
        dem_q[a] <= '0;
        ofs_q[a] <= '0;
      end
    end
    else
    begin
      for (int a = 0; a < NAXES; a++)
      begin
        if (align && sel_ax == AXW'(a))
          dem_q[a] <= meas[a];
        else if (state_q == S_ZERO && ax_q == AXW'(a))
        begin
          dem_q[a] <= '0;
          ofs_q[a] <= ofs_q[a] - dem_q[a];
        end
        else if (ax_q == AXW'(a))
          dem_q[a] <= dem_q[a] + vel_d;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      vel_q      <= '0;
      idx_prev_q <= '0;
      ctl_act_q  <= '0;
    end
    else
    begin
      vel_q      <= vel_d;
      idx_prev_q <= idx_s;
      ctl_act_q  <= ctl_pins_t'(~ctl_s);
    end
  end

  // Status words: sequence 0 clears every axis, a finished search its own
  generate
    for (genvar a = 0; a < NAXES; a++)
    begin : g_stat
      assign clr_ax[a] = align | (state_q == S_ZERO && ax_q == AXW'(a));
      axis_status_word u_stat (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .cond_i (err_cond_i[a]),
        .clr_i  (clr_ax[a]),
        .word_o (stat_w[a])
      );
      assign dem_pos_o[a] = dem_q[a];
    end
  endgenerate

  // Software-written registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      base_q    <= '0;
      irq_msk_q <= '0;
      for (int a = 0; a < NAXES; a++)
      begin
        creep_q[a] <= RST_CREEP;
        speed_q[a] <= RST_SPEED;
        osel_q[a]  <= RST_OSEL;
      end
    end
    else if (wr)
    begin
      if (rgn == RGN_GEN && idx == GEN_BASE)
        base_q <= AXW'(merge(DW'(base_q), wb_dat_i, wb_sel_i));
      if (rgn == RGN_GEN && idx == GEN_IRQ_MSK)
        irq_msk_q <= NIRQ'(merge(DW'(irq_msk_q), wb_dat_i, wb_sel_i));
      if (rgn == RGN_CREEP && ax_ok)
        creep_q[idx_ax] <= SPDW'(merge(DW'(creep_q[idx_ax]), wb_dat_i, wb_sel_i));
      if (rgn == RGN_SPEED && ax_ok)
        speed_q[idx_ax] <= SPDW'(merge(DW'(speed_q[idx_ax]), wb_dat_i, wb_sel_i));
      if (rgn == RGN_OSEL && ax_ok)
        osel_q[idx_ax] <= INSW'(merge(DW'(osel_q[idx_ax]), wb_dat_i, wb_sel_i));
    end
  end

  // Interrupt status: write one to clear, a new event wins over the clear
  logic [NIRQ-1:0] w1c;
  assign irq_ev[IRQ_DONE]  = (state_q == S_ZERO);
  assign irq_ev[IRQ_ALIGN] = align;
  assign irq_ev[IRQ_REJ]   = reject;
  assign w1c = (wr && rgn == RGN_GEN && idx == GEN_IRQ_ST && wb_sel_i[0])
               ? wb_dat_i[NIRQ-1:0] : '0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_st_q <= '0;
    else
      irq_st_q <= (irq_st_q & ~w1c) | irq_ev;
  end

  // Read data
  always_comb
  begin
    rd_d = '0;
    case (rgn)
      RGN_GEN:
        case (idx)
          GEN_CMD:
          begin
            rd_d[CMD_W-1:0] = {ax_q, 1'b0, seq_q};
            rd_d[STATE_LSB +: 3] = state_q;
            rd_d[BUSY_BIT] = (state_q != S_IDLE);
          end
          GEN_BASE:    rd_d[AXW-1:0] = base_q;
          GEN_IRQ_ST:  rd_d[NIRQ-1:0] = irq_st_q;
          GEN_IRQ_MSK: rd_d[NIRQ-1:0] = irq_msk_q;
          GEN_PINS:    rd_d[NCP-1:0] = ctl_act_q;
          default:     rd_d = '0;
        endcase
      RGN_STAT:  if (ax_ok) rd_d[STW-1:0] = stat_w[idx_ax];
      RGN_DEM:   if (ax_ok) rd_d = dem_q[idx_ax];
      RGN_MEAS:  if (ax_ok) rd_d = meas[idx_ax];
      RGN_CREEP: if (ax_ok) rd_d[SPDW-1:0] = creep_q[idx_ax];
      RGN_SPEED: if (ax_ok) rd_d[SPDW-1:0] = speed_q[idx_ax];
      RGN_OSEL:  if (ax_ok) rd_d[INSW-1:0] = osel_q[idx_ax];
      default:   rd_d = '0;
    endcase
  end

  // Every access, mapped or not, is acknowledged one cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end
    else
    begin
      ack_q <= req;
      if (req && !wb_we_i)
        dat_q <= rd_d;
    end
  end

  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = dat_q;
  assign ctl_active_o = ctl_act_q;
  assign vel_o        = vel_q;
  assign vel_axis_o   = ax_q;
  assign busy_o       = (state_q != S_IDLE);
  assign irq_o        = |(irq_st_q & irq_msk_q);

  // Checks
  logic signed [POSW-1:0] dem_cur;
  logic signed [POSW-1:0] ofs_cur;
  logic signed [POSW-1:0] meas_sel;
  logic [SPDW-1:0]        creep_cur;
  logic [SPDW-1:0]        speed_cur;
  logic                   err_left;
  assign dem_cur   = dem_q[ax_q];
  assign ofs_cur   = ofs_q[ax_q];
  assign meas_sel  = meas[sel_ax];
  assign creep_cur = creep_q[ax_q];
  assign speed_cur = speed_q[ax_q];
  always_comb
  begin
    err_left = 1'b0;
    for (int a = 0; a < NAXES; a++)
      err_left = err_left | stat_w[a][ST_FE_WARN] | stat_w[a][ST_COMM_ERR]
                 | stat_w[a][ST_DRV_ERR] | stat_w[a][ST_FOLLOWING_ERROR_LIMIT] | stat_w[a][ST_CANCEL];
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence sw_hit;
    state_q == S_FAST && org_act;
  endsequence
  sequence sw_gone;
    state_q == S_BACK && !org_act;
  endsequence
  sequence creep_run;
    (state_q == S_BACK || state_q == S_ZSEEK) && !ctl_act_q.hold;
  endsequence

  switch_turn_a: assert property (sw_hit |=> state_q == S_BACK && fwd_q != $past(fwd_q))
    else $error("no turn at origin switch");
  switch_leave_a: assert property (sw_gone |=> state_q == ((seq_q >= SEQ_SWZ_FWD)
                                   ? S_ZSEEK : S_ZERO))
    else $error("wrong step after switch release");
  index_stop_a: assert property (state_q == S_ZSEEK && idx_rise
                                 |=> state_q == S_ZERO ##1 state_q == S_IDLE)
    else $error("index marker did not end search");
  creep_speed_a: assert property (creep_run |=> vel_q == ext($past(creep_cur))
                                  || vel_q == -ext($past(creep_cur)))
    else $error("creep speed not used");
  fast_speed_a: assert property (state_q == S_FAST && !ctl_act_q.hold
                                 |=> vel_q == ext($past(speed_cur))
                                 || vel_q == -ext($past(speed_cur)))
    else $error("demand speed not used");
  zero_keep_a: assert property (state_q == S_ZERO |=> dem_cur == '0
                                && ofs_cur == $past(ofs_cur) - $past(dem_cur))
    else $error("finish did not zero demand");
  align_load_a: assert property (align |=> dem_cur == $past(meas_sel)
                                 && state_q == S_IDLE)
    else $error("measured not loaded to demand");
  clear_all_a: assert property (align && err_cond_i == '0 ##1 err_cond_i == '0
                                |-> !err_left)
    else $error("error bits not cleared");
  cause_hold_a: assert property (err_cond_i[0].following_error_limit
                                 |=> stat_w[0][ST_FOLLOWING_ERROR_LIMIT])
    else $error("persisting cause lost its bit");
  reject_keep_a: assert property (reject |=> $stable(ax_q) && $stable(seq_q)
                                  && ($past(state_q) != S_IDLE || state_q == S_IDLE)
                                  && irq_st_q[IRQ_REJ])
    else $error("rejected command changed state");
endmodule : axis_origin_search
`default_nettype wire

// >>> axis_origin_search_tb.sv
/*
  Self-checking bench for axis_origin_search.
  Assumes drive_model stands in for the drive, encoders and switches.
*/
`timescale 1ns/10ps
`default_nettype none
module axis_origin_search_tb;
  import axis_origin_pkg::*;
  localparam logic [5:0] TMASK = 6'b011001;
  logic                       clk_i, rst_i, cyc, stb, we, ack, busy, irq;
  logic [ADR_W-1:0]           adr;
  logic [SELW-1:0]            sel;
  logic [DW-1:0]              wdat, rdat, q;
  logic [NIN-1:0]             gen_in;
  logic [NAXES-1:0]           index;
  ctl_pins_t                  pins, pins_act;
  logic [NAXES-1:0][POSW-1:0] enc, dem;
  err_t [NAXES-1:0]           errc;
  logic signed [POSW-1:0]     vel;
  logic [AXW-1:0]             vax;
  int                         error_cnt, num_checks;

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  axis_origin_search uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .gen_in_i(gen_in), .index_i(index), .ctl_pins_i(pins), .enc_pos_i(enc),
    .err_cond_i(errc), .ctl_active_o(pins_act), .dem_pos_o(dem), .vel_o(vel),
    .vel_axis_o(vax), .busy_o(busy), .irq_o(irq));

  drive_model drv (
    .clk_i(clk_i), .rst_i(rst_i), .vel_i(vel), .vax_i(vax), .enc_o(enc),
    .gen_in_o(gen_in), .index_o(index));

  task conclude;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task chk(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // Values read just after the edge are the ones the slave showed at it
  task xfer(input logic w, input logic [ADR_W-1:0] a, input logic [DW-1:0] d,
            input logic [SELW-1:0] s);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20)
    begin
      error_cnt++;
      conclude();
    end
  endtask : xfer

  task rchk(input logic [ADR_W-1:0] a, input logic [DW-1:0] e);
    xfer(1'b0, a, 32'h0, 4'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask : rchk

  task wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 3000)
    begin
      error_cnt++;
      conclude();
    end
  endtask : wait_idle

  task t_reset;
    chk("busy", 32'h0, 32'(busy));
    chk("irq", 32'h0, 32'(irq));
    rchk(8'h80, 32'(RST_CREEP));
    rchk(8'ha0, 32'(RST_SPEED));
    rchk(8'hc0, 32'(RST_OSEL));
    xfer(1'b1, 8'h8c, 32'hffff, 4'h1);
    rchk(8'h8c, 32'h00ff);
    xfer(1'b1, 8'hec, 32'hffff_ffff, 4'hf);
    rchk(8'hec, 32'h0);
    $display("reset test done");
  endtask : t_reset

  task t_pins;
    for (int i = 0; i < NCP; i++)
    begin
      @(posedge clk_i);
      pins <= ctl_pins_t'(~(5'h1 << i));
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      chk("pin", 32'h1 << i, 32'(pins_act));
    end
    @(posedge clk_i);
    pins <= '1;
    $display("pin test done");
  endtask : t_pins

  task t_align;
    xfer(1'b1, 8'h04, 32'h1, 4'hf);
    xfer(1'b1, 8'h0c, 32'h7, 4'hf);
    errc <= '1;
    @(posedge clk_i);
    errc <= {err_t'(0), err_t'(5'h08), err_t'(0), err_t'(0)};
    rchk({RGN_STAT, 3'd0, 2'b00}, 32'h090e);
    // Issued with no motion running, standing in for a disabled watchdog
    xfer(1'b1, 8'h00, 32'h30, 4'h1);
    @(negedge clk_i);
    chk("busy", 32'h0, 32'(busy));
    for (int a = 0; a < NAXES; a++)
      rchk({RGN_STAT, 3'(a), 2'b00}, (a == 2) ? 32'h100 : 32'h0);
    chk("demand", 32'h111, dem[1]);
    rchk(8'h08, 32'h2);
    xfer(1'b1, 8'h08, 32'h2, 4'hf);
    $display("align test done");
  endtask : t_align

  task t_reject;
    xfer(1'b1, 8'h0c, 32'h3, 4'hf);
    xfer(1'b1, 8'h00, 32'h7, 4'h1);
    @(negedge clk_i);
    chk("busy", 32'h0, 32'(busy));
    chk("irq masked", 32'h0, 32'(irq));
    chk("demand", 32'h111, dem[1]);
    rchk(8'h08, 32'h4);
    xfer(1'b1, 8'h0c, 32'h7, 4'hf);
    @(negedge clk_i);
    chk("irq", 32'h1, 32'(irq));
    xfer(1'b1, 8'h08, 32'h4, 4'hf);
    @(negedge clk_i);
    chk("irq clear", 32'h0, 32'(irq));
    $display("reject test done");
  endtask : t_reject

  task t_search;
    logic [AXW-1:0] ax;
    logic [DW-1:0]  sp;
    for (int a = 0; a < NAXES; a++)
    begin
      xfer(1'b1, {RGN_CREEP, 3'(a), 2'b00}, 32'h20, 4'hf);
      xfer(1'b1, {RGN_SPEED, 3'(a), 2'b00}, 32'h200, 4'hf);
      xfer(1'b1, {RGN_OSEL, 3'(a), 2'b00}, 32'h5, 4'hf);
    end
    for (int s = 1; s <= 6; s++)
    begin
      ax = TMASK[s-1] ? 2'd2 : 2'd1;
      // Axis field is 3 when not temporary, so it must be ignored
      xfer(1'b1, 8'h00, {26'h0, 1'b1, ~TMASK[s-1], TMASK[s-1], 3'(s)}, 4'h1);
      @(negedge clk_i);
      sp = (s <= 2) ? 32'h20 : 32'h200;
      chk("busy", 32'h1, 32'(busy));
      chk("vel", (s % 2 == 1) ? sp : -sp, vel);
      chk("axis", 32'(ax), 32'(vax));
      wait_idle();
      chk("demand", 32'h0, dem[ax]);
      chk("irq", 32'h1, 32'(irq));
      rchk(8'h08, 32'h1);
      xfer(1'b1, 8'h08, 32'h1, 4'hf);
    end
    // Cause gone: sequence 0 must now clear the bit it had to keep
    errc <= '0;
    xfer(1'b1, 8'h00, 32'h0, 4'h1);
    rchk({RGN_STAT, 3'd2, 2'b00}, 32'h0);
    $display("search test done");
  endtask : t_search

  initial
  begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = '0;
    wdat = '0;
    pins = '1;
    errc = '0;
    error_cnt = 0;
    num_checks = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_pins();
    t_align();
    t_reject();
    t_search();
    conclude();
  end
endmodule : axis_origin_search_tb
`default_nettype wire

// >>> axis_status_word.sv
/*
  Status word of one axis: sticky error bits set by drive and loop causes.
  Assumes the causes are levels from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module axis_status_word (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Causes and clear
  input  wire axis_origin_pkg::err_t      cond_i,
  input  wire logic                       clr_i,
  // Status word
  output logic [axis_origin_pkg::STW-1:0] word_o
);
  import axis_origin_pkg::*;

  logic [STW-1:0] cond_w;
  logic [STW-1:0] word_q;

  always_comb
  begin
    cond_w              = '0;
    cond_w[ST_FE_WARN]  = cond_i.fe_warn;
    cond_w[ST_COMM_ERR] = cond_i.comm_err;
    cond_w[ST_DRV_ERR]  = cond_i.drv_err;
    cond_w[ST_FOLLOWING_ERROR_LIMIT] = cond_i.following_error_limit;
    cond_w[ST_CANCEL]   = cond_i.cancel;
  end

  // A cause still present keeps its bit through a clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      word_q <= '0;
    else if (clr_i)
      word_q <= cond_w;
    else
      word_q <= word_q | cond_w;
  end

  assign word_o = word_q;
endmodule : axis_status_word
`default_nettype wire

// >>> drive_model.sv
/*
  Drive, encoder, origin switch and index model for the origin search bench.
  Assumes velocity is a per-cycle step applied to the axis being moved.
*/
`timescale 1ns/10ps
`default_nettype none
module drive_model #(
  parameter int          SWI  = 5,
  parameter logic [31:0] SW   = 32'h0000_1000,
  parameter logic [31:0] ENC0 = 32'h0000_0111
) (
  // Clock and reset
  input  wire logic                                     clk_i,
  input  wire logic                                     rst_i,
  // Motion in
  input  wire logic signed [axis_origin_pkg::POSW-1:0]  vel_i,
  input  wire logic [axis_origin_pkg::AXW-1:0]          vax_i,
  // Feedback out
  output logic [axis_origin_pkg::NAXES-1:0][axis_origin_pkg::POSW-1:0] enc_o,
  output logic [axis_origin_pkg::NIN-1:0]               gen_in_o,
  output logic [axis_origin_pkg::NAXES-1:0]             index_o
);
  import axis_origin_pkg::*;
  logic signed [POSW-1:0] cur;
  assign cur = enc_o[vax_i];
  // Physical position: zeroing the demand must not move it
  always_ff @(posedge clk_i)
    if (rst_i)
      enc_o <= {NAXES{ENC0}};
    else
      enc_o[vax_i] <= enc_o[vax_i] + vel_i;
  // Switch pulls its input low when hit, other inputs idle high
  always_comb
  begin
    gen_in_o = '1;
    gen_in_o[SWI] = !(cur >= $signed(SW) || cur <= -$signed(SW));
    for (int a = 0; a < NAXES; a++)
      index_o[a] = enc_o[a][7:6] == 2'b10;
  end
endmodule : drive_model
`default_nettype wire

// >>> pin_sync.sv
/*
  Two-stage synchroniser for a group of pin inputs.
  Assumes the pins are asynchronous levels; only the second stage is read.
  Reset loads the idle level of the pins, so no false event follows reset.
*/
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Pins in, synchronised out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule : pin_sync
`default_nettype wire
